/* rtl/fault_log_pkg.sv */
// Constants and carrier types for the critical fault log control bank
// Notes on behaviour
// - Selector 00 stores flags and conversion values
// - Selector 01 stores failed-line flags only
// - Selector 10 stores conversion values only
// - Selector 11 stores nothing; logger off
// - Low enable bits 0-7: undervoltage inputs 1-8
// - Mixed enable bits 0-3: undervoltage inputs 9-12
// - Mixed enable bits 4-7: overvoltage inputs 1-4
// - High enable bits 0-6: overvoltage inputs 5-11
// - High enable bit 7: overvoltage input 12
// - Enabled fault shuts supplies; starts log transfer only when idle and selector is not 11
// - Stored log locks until unlock bit written
// - Readable flag set only when enable set
package fault_log_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_OFFSET = 8'h47;
    localparam logic [7:0] UV_EN_LOW_OFFSET = 8'h48;
    localparam logic [7:0] UV_OV_EN_OFFSET = 8'h49;
    localparam logic [7:0] OV_EN_HIGH_OFFSET = 8'h4a;
    localparam logic [7:0] UNLOCK_OFFSET = 8'h5d;
    localparam logic [7:0] FLAGS_LOW_OFFSET = 8'h18;
    localparam logic [7:0] FLAGS_HIGH_OFFSET = 8'h19;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int UNLOCK_BIT = 1;
    localparam int LOCK_STATUS_BIT = 0;
    localparam int MAX_CH = 12;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    localparam logic [7:0] EN_RESET = 8'h00;

    // Log content selector codes
    typedef enum logic [1:0] {
        LOG_BOTH = 2'h0,
        LOG_FLAGS_ONLY = 2'h1,
        LOG_ADC_ONLY = 2'h2,
        LOG_NONE = 2'h3
    } log_sel_t;

    // Request handed to the nonvolatile writer
    typedef struct packed {
        logic store_flags;
        logic store_adc;
        logic [MAX_CH-1:0] failed_lines;
    } log_req_t;

    // Register port access
    typedef struct packed {
        logic wr;
        logic ext_page;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_access_t;
endpackage

/* rtl/fault_flag_bank.sv */
// Readable per-input fault flags with write-one-to-clear
`timescale 1ns/1ns
module fault_flag_bank #(
    parameter int CHANNELS = 12
) (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // Set and clear vectors
    input wire logic [fault_log_pkg::MAX_CH-1:0] set_in,
    input wire logic [fault_log_pkg::MAX_CH-1:0] clear_in,
    // Flag state
    output logic [fault_log_pkg::MAX_CH-1:0] flags_out
);
    logic [fault_log_pkg::MAX_CH-1:0] flags_r;
    logic [fault_log_pkg::MAX_CH-1:0] flags_nxt;

    // One flag per input; absent inputs stay zero
    genvar gi;
    generate
        for (gi = 0; gi < fault_log_pkg::MAX_CH; gi++) begin : g_flag
            if (gi < CHANNELS) begin : g_live
                // Set beats a clear in the same cycle
                always_comb begin
                    flags_nxt[gi] = set_in[gi] | (flags_r[gi] & ~clear_in[gi]);
                end
            end else begin : g_absent
                always_comb begin
                    flags_nxt[gi] = 1'b0;
                end
            end
        end
    endgenerate

    // Flag storage
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            flags_r <= '0;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    assign flags_out = flags_r;
endmodule

/* rtl/critical_fault_log_control.sv */
// Critical fault log control registers, trigger, and lock sequencing
`timescale 1ns/1ns
module critical_fault_log_control #(
    parameter int CHANNELS = 12
) (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // Configuration port access
    input wire fault_log_pkg::reg_access_t reg_in,
    output logic [7:0] reg_rdata_out,
    // Deglitched threshold results, same clock
    input wire logic [fault_log_pkg::MAX_CH-1:0] uv_fault_in,
    input wire logic [fault_log_pkg::MAX_CH-1:0] ov_fault_in,
    // Nonvolatile writer handshake
    input wire logic log_done_in,
    output logic log_start_out,
    output fault_log_pkg::log_req_t log_req_out,
    // Supply control and status
    output logic shutdown_out,
    output logic locked_out
);
    // ------------------------------------------------------------
    // Decode helper
    // ------------------------------------------------------------
    function automatic logic hit(input fault_log_pkg::reg_access_t acc,
                                 input logic [7:0] offset, input logic ext);
        hit = (acc.addr == offset) && (acc.ext_page == ext);
    endfunction

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    logic [1:0] ctrl_r;
    logic [1:0] ctrl_nxt;
    logic [7:0] uv_en_low_r;
    logic [7:0] uv_en_low_nxt;
    logic [7:0] uv_ov_en_r;
    logic [7:0] uv_ov_en_nxt;
    logic [7:0] ov_en_high_r;
    logic [7:0] ov_en_high_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic [fault_log_pkg::MAX_CH-1:0] uv_en;
    logic [fault_log_pkg::MAX_CH-1:0] ov_en;
    logic [fault_log_pkg::MAX_CH-1:0] chan_mask;
    logic [fault_log_pkg::MAX_CH-1:0] hits;
    logic [fault_log_pkg::MAX_CH-1:0] flag_clear;
    logic [fault_log_pkg::MAX_CH-1:0] flags;
    logic crit;
    logic unlock_wr;
    // Lock state lives here because the read mux shows it
    logic locked_r;
    logic locked_nxt;

    // Writes and read mux; only two control bits are kept
    always_comb begin
        ctrl_nxt = ctrl_r;
        uv_en_low_nxt = uv_en_low_r;
        uv_ov_en_nxt = uv_ov_en_r;
        ov_en_high_nxt = ov_en_high_r;
        flag_clear = '0;
        if (reg_in.wr) begin
            if (hit(reg_in, fault_log_pkg::CTRL_OFFSET, 1'b0)) begin
                ctrl_nxt = reg_in.wdata[1:0];
            end
            if (hit(reg_in, fault_log_pkg::UV_EN_LOW_OFFSET, 1'b0)) begin
                uv_en_low_nxt = reg_in.wdata;
            end
            if (hit(reg_in, fault_log_pkg::UV_OV_EN_OFFSET, 1'b0)) begin
                uv_ov_en_nxt = reg_in.wdata;
            end
            if (hit(reg_in, fault_log_pkg::OV_EN_HIGH_OFFSET, 1'b0)) begin
                ov_en_high_nxt = reg_in.wdata;
            end
            if (hit(reg_in, fault_log_pkg::FLAGS_LOW_OFFSET, 1'b1)) begin
                flag_clear[7:0] = reg_in.wdata;
            end
            if (hit(reg_in, fault_log_pkg::FLAGS_HIGH_OFFSET, 1'b1)) begin
                flag_clear[11:8] = reg_in.wdata[3:0];
            end
        end
        rdata_nxt = 8'h00;
        if (hit(reg_in, fault_log_pkg::CTRL_OFFSET, 1'b0)) begin
            rdata_nxt = {6'h00, ctrl_r};
        end else if (hit(reg_in, fault_log_pkg::UV_EN_LOW_OFFSET, 1'b0)) begin
            rdata_nxt = uv_en_low_r;
        end else if (hit(reg_in, fault_log_pkg::UV_OV_EN_OFFSET, 1'b0)) begin
            rdata_nxt = uv_ov_en_r;
        end else if (hit(reg_in, fault_log_pkg::OV_EN_HIGH_OFFSET, 1'b0)) begin
            rdata_nxt = ov_en_high_r;
        end else if (hit(reg_in, fault_log_pkg::UNLOCK_OFFSET, 1'b0)) begin
            rdata_nxt[fault_log_pkg::LOCK_STATUS_BIT] = locked_r;
        end else if (hit(reg_in, fault_log_pkg::FLAGS_LOW_OFFSET, 1'b1)) begin
            rdata_nxt = flags[7:0];
        end else if (hit(reg_in, fault_log_pkg::FLAGS_HIGH_OFFSET, 1'b1)) begin
            rdata_nxt = {4'h0, flags[11:8]};
        end
    end

    // Register storage
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            ctrl_r <= fault_log_pkg::CTRL_RESET;
            uv_en_low_r <= fault_log_pkg::EN_RESET;
            uv_ov_en_r <= fault_log_pkg::EN_RESET;
            ov_en_high_r <= fault_log_pkg::EN_RESET;
            rdata_r <= 8'h00;
        end else begin
            ctrl_r <= ctrl_nxt;
            uv_en_low_r <= uv_en_low_nxt;
            uv_ov_en_r <= uv_ov_en_nxt;
            ov_en_high_r <= ov_en_high_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // ------------------------------------------------------------
    // Trigger qualification
    // ------------------------------------------------------------
    // undervoltage and overvoltage enable maps
    assign uv_en = {uv_ov_en_r[3:0], uv_en_low_r};
    assign ov_en = {ov_en_high_r, uv_ov_en_r[7:4]};
    // Inputs missing on the smaller variant never trigger
    assign chan_mask = fault_log_pkg::MAX_CH'((1 << CHANNELS) - 1);
    assign hits = ((uv_fault_in & uv_en) | (ov_fault_in & ov_en)) & chan_mask;
    assign crit = |hits;
    assign unlock_wr = reg_in.wr && hit(reg_in, fault_log_pkg::UNLOCK_OFFSET, 1'b0)
                       && reg_in.wdata[fault_log_pkg::UNLOCK_BIT];

    fault_flag_bank #(
        .CHANNELS(CHANNELS)
    ) u_flags (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .set_in(hits),
        .clear_in(flag_clear),
        .flags_out(flags)
    );

    // ------------------------------------------------------------
    // Log sequencing
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_STORE = 3'b010,
        ST_LOCKED = 3'b100
    } log_state_t;

    log_state_t state_r;
    log_state_t state_nxt;
    logic start_r;
    logic start_nxt;
    logic shutdown_r;
    logic shutdown_nxt;
    fault_log_pkg::log_req_t req_r;
    fault_log_pkg::log_req_t req_nxt;

    // Trigger, store and lock; shutdown holds until reset
    always_comb begin
        state_nxt = state_r;
        start_nxt = 1'b0;
        req_nxt = req_r;
        locked_nxt = locked_r;
        shutdown_nxt = shutdown_r | crit;
        unique case (state_r)
            ST_IDLE: begin
                if (crit && ctrl_r != fault_log_pkg::LOG_NONE) begin
                    req_nxt.store_flags = (ctrl_r != fault_log_pkg::LOG_ADC_ONLY);
                    req_nxt.store_adc = (ctrl_r != fault_log_pkg::LOG_FLAGS_ONLY);
                    req_nxt.failed_lines = hits;
                    start_nxt = 1'b1;
                    state_nxt = ST_STORE;
                end
            end
            ST_STORE: begin
                if (log_done_in) begin
                    state_nxt = ST_LOCKED;
                    locked_nxt = 1'b1;
                end
            end
            ST_LOCKED: begin
                if (unlock_wr) begin
                    state_nxt = ST_IDLE;
                    locked_nxt = 1'b0;
                end
            end
        endcase
    end

    // Sequencer storage
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            state_r <= ST_IDLE;
            start_r <= 1'b0;
            shutdown_r <= 1'b0;
            locked_r <= 1'b0;
            req_r <= '0;
        end else begin
            state_r <= state_nxt;
            start_r <= start_nxt;
            shutdown_r <= shutdown_nxt;
            locked_r <= locked_nxt;
            req_r <= req_nxt;
        end
    end

    assign reg_rdata_out = rdata_r;
    assign log_start_out = start_r;
    assign log_req_out = req_r;
    assign shutdown_out = shutdown_r;
    assign locked_out = locked_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);

    both_content_a: assert property (
        state_r == ST_IDLE && crit && ctrl_r == 2'h0 |=> log_start_out
        && log_req_out.store_flags && log_req_out.store_adc)
        else $error("selector 00 did not request both");
    flags_only_a: assert property (
        state_r == ST_IDLE && crit && ctrl_r == 2'h1 |=> log_start_out
        && log_req_out.store_flags && !log_req_out.store_adc)
        else $error("selector 01 wrong content");
    adc_only_a: assert property (
        state_r == ST_IDLE && crit && ctrl_r == 2'h2 |=> log_start_out
        && !log_req_out.store_flags && log_req_out.store_adc)
        else $error("selector 10 wrong content");
    logger_off_a: assert property (
        ctrl_r == 2'h3 && state_r == ST_IDLE |=> !log_start_out)
        else $error("log started with logger off");
    uv_low_a: assert property (
        (uv_fault_in[7:0] & uv_en_low_r) != 8'h00 |=> shutdown_out)
        else $error("enabled low undervoltage ignored");
    uv_high_a: assert property (
        CHANNELS == 12 && (uv_fault_in[11:8] & uv_ov_en_r[3:0]) != 4'h0 |=> shutdown_out)
        else $error("enabled high undervoltage ignored");
    ov_low_a: assert property (
        (ov_fault_in[3:0] & uv_ov_en_r[7:4]) != 4'h0 |=> shutdown_out)
        else $error("enabled low overvoltage ignored");
    ov_high_a: assert property (
        (ov_fault_in[10:4] & ov_en_high_r[6:0] & chan_mask[10:4]) != 7'h00 |=> shutdown_out)
        else $error("enabled mid overvoltage ignored");
    ov_top_a: assert property (
        CHANNELS == 12 && ov_fault_in[11] && ov_en_high_r[7] |=> shutdown_out)
        else $error("input 12 overvoltage ignored");
    lock_hold_a: assert property (
        locked_out && !unlock_wr |=> locked_out && !log_start_out)
        else $error("lock released without unlock");
    flag_gate_a: assert property (
        !flags[0] && !(uv_fault_in[0] && uv_en_low_r[0])
        && !(ov_fault_in[0] && uv_ov_en_r[4]) |=> !flags[0])
        else $error("flag set without enable");
    ctrl_zero_a: assert property (
        hit(reg_in, fault_log_pkg::CTRL_OFFSET, 1'b0) |=> reg_rdata_out[7:2] == 6'h00)
        else $error("control upper bits not zero");

    store_c: cover property (log_start_out ##[1:20] locked_out);
    unlock_c: cover property (locked_out ##1 !locked_out);
    off_c: cover property (ctrl_r == 2'h3 && crit);
endmodule

/* verification/tb_top.sv */
// Self-checking bench for the critical fault log control bank
`timescale 1ns/1ns
module tb_top;
    // ------------------------------------------------------------
    // Signals and bench model state
    // ------------------------------------------------------------
    logic clk_sys_in = 1'b0;
    logic rst_in = 1'b1;
    fault_log_pkg::reg_access_t reg_in = '0;
    logic [7:0] reg_rdata_out;
    logic [fault_log_pkg::MAX_CH-1:0] uv_fault_in = '0;
    logic [fault_log_pkg::MAX_CH-1:0] ov_fault_in = '0;
    logic log_done_in = 1'b0;
    logic log_start_out;
    fault_log_pkg::log_req_t log_req_out;
    logic shutdown_out;
    logic locked_out;
    int bad_count = 0;
    int comparisons = 0;
    logic [7:0] rd;
    // Model of expected log requests, oldest first
    logic [13:0] exp_log_q[$];

    critical_fault_log_control #(.CHANNELS(12)) DUT (
        .clk_sys_in(clk_sys_in), .rst_in(rst_in), .reg_in(reg_in),
        .reg_rdata_out(reg_rdata_out), .uv_fault_in(uv_fault_in),
        .ov_fault_in(ov_fault_in), .log_done_in(log_done_in),
        .log_start_out(log_start_out), .log_req_out(log_req_out),
        .shutdown_out(shutdown_out), .locked_out(locked_out));

    // 100 ns period
    initial begin
        forever #50 clk_sys_in = ~clk_sys_in;
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Strobe held for one edge only, dropped at the next falling edge
    task automatic wr_reg(input logic ext, input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys_in);
        reg_in = {1'b1, ext, a, d};
        @(negedge clk_sys_in);
        reg_in.wr = 1'b0;
    endtask

    // Read data is registered, so it is sampled one edge after the address
    task automatic rd_reg(input logic ext, input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_sys_in);
        reg_in = {1'b0, ext, a, 8'h00};
        @(negedge clk_sys_in);
        d = reg_rdata_out;
    endtask

    task automatic do_reset(input int n);
        @(negedge clk_sys_in);
        rst_in = 1'b1;
        repeat (n) @(negedge clk_sys_in);
        rst_in = 1'b0;
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // One trigger case: enables, faults, request, flags, lock
    // ------------------------------------------------------------
    task automatic run_case(input int i);
        logic [1:0] sel;
        logic [11:0] uv_en;
        logic [11:0] ov_en;
        logic [11:0] uv;
        logic [11:0] ov;
        logic [11:0] hits;
        logic started;
        sel = 2'(i % 4);
        uv_en = (i < 12) ? 12'(1 << i) : 12'h000;
        ov_en = (i >= 12 && i < 24) ? 12'(1 << (i - 12)) : 12'h000;
        if (i >= 24) begin
            uv_en = 12'($urandom());
            ov_en = 12'($urandom());
        end
        // Unenabled background faults must not count
        uv = 12'($urandom());
        ov = 12'($urandom());
        if (i < 12) uv[i] = 1'b1;
        else if (i < 24) ov[i - 12] = 1'b1;
        hits = (uv & uv_en) | (ov & ov_en);
        started = (hits != 12'h000) && (sel != 2'h3);
        do_reset(2);
        wr_reg(1'b0, 8'h47, {6'h00, sel});
        wr_reg(1'b0, 8'h48, uv_en[7:0]);
        wr_reg(1'b0, 8'h49, {ov_en[3:0], uv_en[11:8]});
        wr_reg(1'b0, 8'h4a, ov_en[11:4]);
        rd_reg(1'b0, 8'h47, rd);
        check("ctrl readback", {6'h00, sel}, rd); // Control field
        @(negedge clk_sys_in);
        uv_fault_in = uv;
        ov_fault_in = ov;
        @(negedge clk_sys_in);
        check("shutdown", hits != 12'h000, shutdown_out); // Trigger map
        check("start", started, log_start_out); // Start pulse
        if (started) begin
            exp_log_q.push_back({~sel[1], ~sel[0], hits});
        end
        if (exp_log_q.size() > 0) begin
            check("request", exp_log_q.pop_front(), log_req_out); // Content
        end
        @(negedge clk_sys_in);
        check("start width", 1'b0, log_start_out); // One cycle pulse
        uv_fault_in = '0;
        ov_fault_in = '0;
        rd_reg(1'b1, 8'h18, rd);
        check("flags low", hits[7:0], rd); // Masked flags
        rd_reg(1'b1, 8'h19, rd);
        check("flags high", {4'h0, hits[11:8]}, rd); // Masked flags
        wr_reg(1'b1, 8'h18, 8'hff);
        wr_reg(1'b1, 8'h19, 8'h0f);
        rd_reg(1'b1, 8'h18, rd);
        check("flags cleared", 8'h00, rd); // Write one clears
        // Writer finishes; lock only if a log was started
        @(negedge clk_sys_in);
        log_done_in = 1'b1;
        @(negedge clk_sys_in);
        log_done_in = 1'b0;
        check("locked", started, locked_out); // Lock after store
        rd_reg(1'b0, 8'h5d, rd);
        check("lock status", started, rd[0]); // Lock status
        if (started) begin
            uv_fault_in = 12'hfff;
            ov_fault_in = 12'hfff;
            @(negedge clk_sys_in);
            check("start while locked", 1'b0, log_start_out); // Refused
            uv_fault_in = '0;
            ov_fault_in = '0;
            wr_reg(1'b0, 8'h5d, 8'h02);
            check("unlocked", 1'b0, locked_out); // Unlock write
        end
        $display("case %0d sel %0d hits %h done", i, sel, hits);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(11422));
        do_reset(8);
        check("reset shutdown", 1'b0, shutdown_out); // Supplies on after reset
        check("reset locked", 1'b0, locked_out); // Unlocked after reset
        // Register reset values all zero
        for (int a = 8'h47; a <= 8'h4a; a++) begin
            rd_reg(1'b0, 8'(a), rd);
            check("reset value", 8'h00, rd); // Reset state
        end
        wr_reg(1'b0, 8'h47, 8'hff);
        rd_reg(1'b0, 8'h47, rd);
        check("ctrl upper bits", 8'h03, rd); // Unused bits zero
        wr_reg(1'b0, 8'h50, 8'h5a);
        rd_reg(1'b0, 8'h50, rd);
        check("unmapped", 8'h00, rd); // Stray writes ignored
        $display("register test done");
        for (int i = 0; i < 32; i++) begin
            run_case(i);
        end
        final_report();
    end

    // Tests take about a thousand cycles; a hang stops well past that
    initial begin
        #2000000;
        bad_count++;
        $display("ERROR watchdog expected finish seen timeout");
        final_report();
    end
endmodule
